// ### core/swc_top.v
/*
 * Sleep and wake sequencer of a small 8-bit controller core: stops the core
 * oscillator on the sleep instruction, holds the ports, keeps the power-down
 * and time-out flags, and wakes on reset, watchdog or enabled interrupt.
 * Assumes the controller clock never stops; the core clock is gated by
 * osc_run_o, and core strobes are one cycle long on that same clock.
 */
`timescale 1ns/1ps
`include "swc_regs.vh"

// Functional notes
// - The sleep instruction puts the device into power-down.
// - Entering sleep clears the watchdog, which keeps counting while asleep.
// - Entering sleep clears the power-down flag and sets the time-out flag.
// - In power-down the oscillator driver is off, stopping the core clock.
// - In power-down every port keeps its pre-sleep drive state.
// - A watchdog reset is internal and never pulls the master clear pin.
// - Master clear asserted during sleep wakes with a full device reset.
// - Watchdog or interrupt wake resumes execution without reset.
// - Power-down flag is set at power-up and cleared by sleep.
// - A watchdog wake clears the time-out flag.
// - While sleep executes, the next instruction is prefetched.
// - Only individually enabled interrupts wake, whatever the global enable.
// - After interrupt wake run the prefetched instruction, then vector if enabled.
// - Enabled pending interrupt with global enable off: sleep completes, wake at once.
// - The watchdog is cleared on every wake, whatever the cause.
// - Crystal modes wait 1024 oscillator periods before resuming.
// - Watchdog time-out resets while running and wakes while asleep.
// - Watchdog clear and sleep clear the watchdog and its prescaler.
// - Interrupt flags set on their events regardless of any enable.
module swc_top #(
  parameter integer WDT_CYCLES = `SWC_WDT_CYC
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [13:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire sleep_exec_i,
  input wire watchdog_clear_instr_i,
  input wire irq_ack_i,
  input wire port_change_i,
  input wire periph_irq_i,
  input wire external_irq_pin_i,
  input wire master_clear_pin_n_i,
  input wire [7:0] config_strap_i,
  output reg osc_run_o,
  output reg port_hold_o,
  output reg core_rst_n_o,
  output reg prefetch_o,
  output reg resume_o,
  output reg branch_vec_o,
  output reg irq_req_o
);
  localparam [2:0] S_RST = 3'h0;
  localparam [2:0] S_RUN = 3'h1;
  localparam [2:0] S_SLEEP = 3'h2;
  localparam [2:0] S_OST = 3'h3;
  localparam [2:0] S_RESUME = 3'h4;
  // Load values are worked out at full width, then cut to the counter widths.
  localparam integer OST_LOAD_I = `SWC_OST_CYC - 1;
  localparam integer RST_LOAD_I = `SWC_RST_HOLD_CYC - 1;
  localparam [10:0] OST_LOAD = OST_LOAD_I[10:0];
  localparam [4:0] RST_LOAD = RST_LOAD_I[4:0];

  reg rst_a_q;
  reg rst_s_q;
  wire rst_n;
  wire master_clear_pin_n_s;
  wire ext_pin_s;
  wire [7:0] cfg_s;
  reg ext_prev_q;
  reg [1:0] cfg_wait_q;
  reg [7:0] config_q;
  reg [7:0] option_q;
  reg [7:0] irqc_q;
  reg [7:0] irqc_d;
  reg pd_q;
  reg to_q;
  reg [2:0] state_q;
  reg [10:0] ost_q;
  reg [4:0] rst_cnt_q;
  reg wdt_clr;
  wire wdt_to;
  wire ext_edge;
  wire pend_en;
  wire wdt_en;
  wire xtal_mode;

  // Reset release through two flops; assertion stays asynchronous.
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_a_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_s_q <= rst_a_q;
    end
  end
  assign rst_n = rst_s_q;

  swc_sync #(
    .W(10)
  ) u_sync (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .d_i({master_clear_pin_n_i, external_irq_pin_i, config_strap_i}),
    .q_o({master_clear_pin_n_s, ext_pin_s, cfg_s})
  );

  // The configuration word is a strap, caught after reset release. The
  // synchroniser leaves reset at zero, so the capture follows it until its
  // second stage holds a real sample of the strap pins.
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cfg_wait_q <= 2'h0;
      config_q <= 8'h00;
    end else if (cfg_wait_q != 2'h3) begin
      cfg_wait_q <= cfg_wait_q + 2'h1;
      config_q <= cfg_s;
    end
  end

  assign wdt_en = config_q[`SWC_CFG_WATCHDOG_ENABLE_FUSE];
  assign xtal_mode = (config_q[2:0] == 3'h0) || (config_q[2:0] == 3'h1) ||
    (config_q[2:0] == 3'h2);

  // Edge select follows the option register; the flag then stays sticky.
  assign ext_edge = option_q[`SWC_OPT_EDGE] ? (ext_pin_s && !ext_prev_q) :
    (!ext_pin_s && ext_prev_q);

  // Individually enabled sources only; the global enable plays no part here.
  assign pend_en = (irqc_q[`SWC_IC_INTE] && irqc_q[`SWC_IC_INTF]) ||
    (irqc_q[`SWC_IC_RAIE] && irqc_q[`SWC_IC_RAIF]) ||
    (irqc_q[`SWC_IC_PEIE] && periph_irq_i);

  swc_wdt #(
    .CYCLES(WDT_CYCLES)
  ) u_wdt (
    .clk_i(mclk_i),
    .rst_n_i(rst_n),
    .clear_i(wdt_clr),
    .enable_i(wdt_en),
    .psa_i(option_q[`SWC_OPT_PSA]),
    .ps_i(option_q[2:0]),
    .timeout_o(wdt_to)
  );

  // Watchdog clear requests from instructions, sleep, wake and reset.
  always @* begin
    wdt_clr = 1'b0;
    case (state_q)
      S_RST: wdt_clr = 1'b1;
      S_RUN: wdt_clr = watchdog_clear_instr_i || sleep_exec_i;
      S_SLEEP: wdt_clr = wdt_to || pend_en;
      default: wdt_clr = 1'b0;
    endcase
  end

  // Flags set by events win over a software clear in the same cycle.
  always @* begin
    irqc_d = irqc_q;
    if (wr_i && addr_i == `SWC_IRQ_CTRL_ADDR) begin
      irqc_d = wdata_i & 8'hdb;
    end
    if (state_q == S_RUN && irq_ack_i) begin
      irqc_d[`SWC_IC_GIE] = 1'b0;
    end
    if (ext_edge) begin
      irqc_d[`SWC_IC_INTF] = 1'b1;
    end
    if (port_change_i) begin
      irqc_d[`SWC_IC_RAIF] = 1'b1;
    end
  end

  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_prev_q <= 1'b0;
      irqc_q <= `SWC_IRQ_CTRL_RST;
      option_q <= `SWC_OPTION_RST;
    end else begin
      ext_prev_q <= ext_pin_s;
      if (state_q == S_RST) begin
        irqc_q <= `SWC_IRQ_CTRL_RST;
        option_q <= `SWC_OPTION_RST;
      end else begin
        irqc_q <= irqc_d;
        if (wr_i && addr_i == `SWC_OPTION_ADDR) begin
          option_q <= wdata_i;
        end
      end
    end
  end

  // Register read port; unmapped addresses read as zero.
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `SWC_STATUS_ADDR: rdata_o <= {3'h0, to_q, pd_q, 3'h0};
        `SWC_IRQ_CTRL_ADDR: rdata_o <= irqc_q;
        `SWC_OPTION_ADDR: rdata_o <= option_q;
        `SWC_CONFIG_ADDR: rdata_o <= config_q;
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Power-down and time-out flags; both survive a master clear.
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      pd_q <= 1'b1;
      to_q <= 1'b1;
    end else begin
      case (state_q)
        S_RUN: begin
          // A time-out while running marks the watchdog as the reset cause.
          if (wdt_to && wdt_en && master_clear_pin_n_s) begin
            to_q <= 1'b0;
          end else if (sleep_exec_i) begin
            pd_q <= 1'b0;
            to_q <= 1'b1;
          end else if (watchdog_clear_instr_i) begin
            pd_q <= 1'b1;
            to_q <= 1'b1;
          end
        end
        S_SLEEP: begin
          if (wdt_to) begin
            to_q <= 1'b0;
          end
        end
        default: begin
          pd_q <= pd_q;
        end
      endcase
    end
  end

  // Sequencer. It runs on the always-on clock, so wake sources are seen
  // while the core clock is stopped.
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_RST;
      ost_q <= 11'h000;
      rst_cnt_q <= RST_LOAD;
      osc_run_o <= 1'b1;
      port_hold_o <= 1'b0;
      core_rst_n_o <= 1'b0;
      prefetch_o <= 1'b0;
      resume_o <= 1'b0;
      branch_vec_o <= 1'b0;
      irq_req_o <= 1'b0;
    end else begin
      prefetch_o <= 1'b0;
      resume_o <= 1'b0;
      irq_req_o <= 1'b0;
      if (!master_clear_pin_n_s) begin
        // The pin is only sampled; no internal reset ever drives it.
        state_q <= S_RST;
        rst_cnt_q <= RST_LOAD;
        osc_run_o <= 1'b1;
        port_hold_o <= 1'b0;
        core_rst_n_o <= 1'b0;
        branch_vec_o <= 1'b0;
      end else begin
        case (state_q)
          S_RST: begin
            if (rst_cnt_q == 5'h00) begin
              core_rst_n_o <= 1'b1;
              state_q <= S_RUN;
            end else begin
              rst_cnt_q <= rst_cnt_q - 5'h01;
            end
          end
          S_RUN: begin
            // No request goes out in the cycle that a time-out puts the core
            // into reset, since the core would lose it anyway.
            irq_req_o <= irqc_q[`SWC_IC_GIE] && pend_en && !wdt_to;
            if (wdt_to) begin
              // Internal reset only; the master clear pin is untouched.
              state_q <= S_RST;
              rst_cnt_q <= RST_LOAD;
              core_rst_n_o <= 1'b0;
              branch_vec_o <= 1'b0;
            end else if (sleep_exec_i) begin
              prefetch_o <= 1'b1;
              if (pend_en) begin
                // Sleep completes but the clock never stops.
                state_q <= S_RESUME;
              end else begin
                state_q <= S_SLEEP;
                osc_run_o <= 1'b0;
                port_hold_o <= 1'b1;
              end
            end
          end
          S_SLEEP: begin
            if (wdt_to || pend_en) begin
              osc_run_o <= 1'b1;
              if (xtal_mode) begin
                ost_q <= OST_LOAD;
                state_q <= S_OST;
              end else begin
                state_q <= S_RESUME;
              end
            end
          end
          S_OST: begin
            if (ost_q == 11'h000) begin
              state_q <= S_RESUME;
            end else begin
              ost_q <= ost_q - 11'h001;
            end
          end
          S_RESUME: begin
            // The core runs the prefetched instruction, then vectors if the global enable is set and an enabled interrupt is pending.
            resume_o <= 1'b1;
            branch_vec_o <= irqc_q[`SWC_IC_GIE] && pend_en;
            port_hold_o <= 1'b0;
            osc_run_o <= 1'b1;
            state_q <= S_RUN;
          end
          default: begin
            state_q <= S_RST;
            rst_cnt_q <= RST_LOAD;
            core_rst_n_o <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// ### core/swc_regs.vh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * sleep and wake controller. Assumes a 20 MHz controller clock and a
 * 14-bit register address with 8-bit data.
 */
`ifndef SWC_REGS_VH
`define SWC_REGS_VH

`define SWC_ADDR_W 14
`define SWC_STATUS_ADDR 14'h0003
`define SWC_IRQ_CTRL_ADDR 14'h000b
`define SWC_OPTION_ADDR 14'h0081
`define SWC_CONFIG_ADDR 14'h2007

`define SWC_OPTION_RST 8'hff
`define SWC_IRQ_CTRL_RST 8'h00

`define SWC_OPT_EDGE 6
`define SWC_OPT_PSA 3
`define SWC_CFG_WATCHDOG_ENABLE_FUSE 3
`define SWC_ST_TO 4
`define SWC_ST_PD 3
`define SWC_IC_GIE 7
`define SWC_IC_PEIE 6
`define SWC_IC_INTE 4
`define SWC_IC_RAIE 3
`define SWC_IC_INTF 1
`define SWC_IC_RAIF 0

`define SWC_MCLK_NS 50
`define SWC_MCLK_KHZ 20000
`define SWC_TOSC_NS 50
`define SWC_OST_TOSC 1024
`define SWC_OST_CYC ((`SWC_OST_TOSC * `SWC_TOSC_NS + `SWC_MCLK_NS - 1) / `SWC_MCLK_NS)
`define SWC_WDT_MS 18
`define SWC_WDT_CYC (`SWC_WDT_MS * `SWC_MCLK_KHZ)
`define SWC_RST_HOLD_CYC 16

`endif

// ### core/swc_sync.v
/*
 * Two-stage synchroniser for a bus of levels.
 * Assumes the inputs change slowly against the controller clock.
 */
`timescale 1ns/1ps
module swc_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// ### core/swc_wdt.v
/*
 * Watchdog counter with optional prescaler and a one-cycle time-out pulse.
 * Assumes it is clocked by the always-running controller clock.
 */
`timescale 1ns/1ps
module swc_wdt #(
  parameter integer CYCLES = 360000
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire clear_i,
  input wire enable_i,
  input wire psa_i,
  input wire [2:0] ps_i,
  output reg timeout_o
);
  localparam integer LAST_I = CYCLES - 1;
  localparam [19:0] LAST = LAST_I[19:0];
  reg [19:0] base_q;
  reg [6:0] pre_q;

  function [6:0] ratio_last;
    input [2:0] ps;
    begin
      ratio_last = (7'h01 << ps) - 7'h01;
    end
  endfunction

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_q <= 20'h0_0000;
      pre_q <= 7'h00;
      timeout_o <= 1'b0;
    end else if (clear_i || !enable_i) begin
      base_q <= 20'h0_0000;
      pre_q <= 7'h00;
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= 1'b0;
      if (base_q == LAST) begin
        base_q <= 20'h0_0000;
        if (!psa_i || pre_q == ratio_last(ps_i)) begin
          pre_q <= 7'h00;
          timeout_o <= 1'b1;
        end else begin
          pre_q <= pre_q + 7'h01;
        end
      end else begin
        base_q <= base_q + 20'h0_0001;
      end
    end
  end
endmodule

// ### verification/swc_top_asserts.sv
/* Port checker of the sleep and wake sequencer, bound into swc_top.
   Assumes the oscillator strap stays fixed between resets. */
`timescale 1ns/1ps
module swc_top_asserts (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [13:0] addr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  input wire sleep_exec_i,
  input wire master_clear_pin_n_i,
  input wire [7:0] config_strap_i,
  input wire osc_run_o,
  input wire port_hold_o,
  input wire core_rst_n_o,
  input wire prefetch_o,
  input wire resume_o,
  input wire branch_vec_o,
  input wire irq_req_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire run = osc_run_o && !port_hold_o && core_rst_n_o;
  // Four steady samples cover the pin synchroniser, so a pin reset is not misread.
  sequence s_pin_high;
    master_clear_pin_n_i [*4];
  endsequence
  sequence s_pin_low;
    !master_clear_pin_n_i [*4];
  endsequence
  sequence s_sleep;
    sleep_exec_i && run;
  endsequence
  prefetch_next_a:
    assert property (s_sleep |=> prefetch_o) else $error("No prefetch after sleep.");
  prefetch_cause_a:
    assert property (prefetch_o |-> $past(sleep_exec_i)) else $error("Stray prefetch.");
  port_hold_a:
    assert property (!osc_run_o |-> port_hold_o) else $error("Ports not held.");
  wake_resume_a:
    assert property (s_pin_high ##0 ($rose(osc_run_o) && config_strap_i[2:0] > 3'h2)
      |=> resume_o && !port_hold_o) else $error("Late resume.");
  sleep_no_reset_a:
    assert property (s_pin_high ##0 !osc_run_o |=> core_rst_n_o) else $error("Reset in sleep.");
  pin_reset_a:
    assert property (s_pin_low |-> ##[0:2] !core_rst_n_o) else $error("Pin reset missed.");
  reset_hold_a:
    assert property ($rose(core_rst_n_o) |-> $past(core_rst_n_o, 16) == 1'b0)
      else $error("Short reset.");
  status_shape_a:
    assert property (rd_i && addr_i == 14'h0003 |=> (rdata_o & 8'he7) == 8'h00)
      else $error("Status spare bits set.");
  irq_run_a:
    assert property (irq_req_o |-> run) else $error("Request outside run.");
  branch_at_resume_a:
    assert property ($changed(branch_vec_o) |-> resume_o || !core_rst_n_o)
      else $error("Branch moved off resume.");
endmodule
bind swc_top swc_top_asserts u_chk (.mclk_i, .rst_n_i, .addr_i, .rd_i, .rdata_o,
  .sleep_exec_i, .master_clear_pin_n_i, .config_strap_i, .osc_run_o, .port_hold_o,
  .core_rst_n_o, .prefetch_o, .resume_o, .branch_vec_o, .irq_req_o);

// ### verification/swc_core_model.sv
/* Behavioural core beside the sequencer: issues sleep and watchdog clear.
   Assumes the bench asks for them with one-cycle requests. */
`timescale 1ns/1ps
module swc_core_model (
  input wire mclk_i,
  input wire osc_run_i,
  input wire core_rst_n_i,
  input wire sleep_req_i,
  input wire clr_req_i,
  output reg sleep_exec_o,
  output reg watchdog_clear_instr_o
);
  // The core clock is gated, so a stopped or reset core issues nothing.
  wire live = osc_run_i && core_rst_n_i;
  initial begin
    sleep_exec_o = 1'b0;
    watchdog_clear_instr_o = 1'b0;
  end
  always @(posedge mclk_i) begin
    sleep_exec_o <= sleep_req_i && live;
    // A watchdog clear in the slot after a sleep is dropped; a sleep request there still issues.
    watchdog_clear_instr_o <= clr_req_i && live && !sleep_exec_o;
  end
endmodule

// ### verification/swc_top_bench.sv
/* Bench of the sleep and wake sequencer beside a core model, watchdog cut to 64.
   Assumes the checker binds itself into swc_top. */
`timescale 1ns/1ps
module swc_top_bench;
  reg mclk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [13:0] addr_i = 14'h0000;
  reg [7:0] wdata_i = 8'h00;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg irq_ack_i = 1'b0;
  reg port_change_i = 1'b0;
  reg periph_irq_i = 1'b0;
  reg external_irq_pin_i = 1'b0;
  reg master_clear_pin_n_i = 1'b1;
  reg [7:0] config_strap_i = 8'h0f;
  reg sleep_q = 1'b0;
  reg clr_q = 1'b0;
  wire sleep_exec_i, watchdog_clear_instr_i, osc_run_o, port_hold_o, core_rst_n_o;
  wire prefetch_o, resume_o, branch_vec_o, irq_req_o;
  wire [7:0] rdata_o;
  int n_fail = 0;
  int n_tests = 0;
  int n;
  swc_top #(.WDT_CYCLES(64)) u_dut (.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .sleep_exec_i, .watchdog_clear_instr_i, .irq_ack_i, .port_change_i,
    .periph_irq_i, .external_irq_pin_i, .master_clear_pin_n_i, .config_strap_i,
    .osc_run_o, .port_hold_o, .core_rst_n_o, .prefetch_o, .resume_o, .branch_vec_o,
    .irq_req_o);
  swc_core_model u_core (.mclk_i, .osc_run_i(osc_run_o), .core_rst_n_i(core_rst_n_o),
    .sleep_req_i(sleep_q), .clr_req_i(clr_q), .sleep_exec_o(sleep_exec_i),
    .watchdog_clear_instr_o(watchdog_clear_instr_i));
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  task close_out;
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task wreg(input [13:0] a, input [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task rreg(input [13:0] a, input [7:0] e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
    chk(rdata_o, e);
  endtask
  // Waits for resume (0), core out of reset (1) or core in reset (2).
  task wait_for(input int lim, input [1:0] what);
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while ((what == 0 ? resume_o : what == 1 ? core_rst_n_o : !core_rst_n_o) !== 1'b1
      && n < lim);
  endtask
  task chg;
    port_change_i <= 1'b1;
    @(posedge mclk_i);
    port_change_i <= 1'b0;
  endtask
  task go_sleep(input [7:0] stop);
    sleep_q <= 1'b1;
    @(posedge mclk_i);
    sleep_q <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk(prefetch_o, 8'h01);
    chk(osc_run_o, ~stop & 8'h01);
    chk(port_hold_o, stop);
  endtask
  task t_reset;
    wait_for(40, 1);
    chk(n > 16 && n < 40, 8'h01);
    rreg(14'h0003, 8'h18);
    rreg(14'h0081, 8'hff);
    wreg(14'h2007, 8'h00);
    wreg(14'h0003, 8'h00);
    rreg(14'h2007, 8'h0f);
    rreg(14'h0003, 8'h18);
    rreg(14'h0100, 8'h00);
  endtask
  task t_wdclr;
    repeat (5) begin
      clr_q <= 1'b1;
      @(posedge mclk_i);
      clr_q <= 1'b0;
      wreg(14'h0081, 8'hf7);
      repeat (36) @(posedge mclk_i);
    end
    chk(core_rst_n_o, 8'h01);
    rreg(14'h0003, 8'h18);
    wait_for(90, 2);
    chk(n > 25 && n < 29, 8'h01);
    rreg(14'h0003, 8'h08);
    wait_for(40, 1);
  endtask
  task t_wdt_sleep;
    wreg(14'h0081, 8'hf7);
    wreg(14'h000b, 8'h00);
    go_sleep(8'h01);
    rreg(14'h0003, 8'h10);
    wait_for(90, 0);
    chk(n > 50 && n < 75, 8'h01);
    chk(core_rst_n_o, 8'h01);
    rreg(14'h0003, 8'h00);
    wait_for(90, 2);
    chk(n > 50 && n < 80, 8'h01);
    wait_for(40, 1);
  endtask
  task t_irq;
    for (int i = 0; i < 6; i++) begin
      // Port, pin and peripheral sources in turn, global enable off then on.
      wreg(14'h000b, (i < 2 ? 8'h08 : i < 4 ? 8'h10 : 8'h40) | {i[0], 7'h00});
      go_sleep(8'h01);
      port_change_i <= (i < 2);
      external_irq_pin_i <= (i == 2 || i == 3);
      periph_irq_i <= (i > 3);
      @(posedge mclk_i);
      port_change_i <= 1'b0;
      wait_for(20, 0);
      chk(n < 20, 8'h01);
      chk(branch_vec_o, i[0]);
      repeat (2) @(posedge mclk_i);
      chk(irq_req_o, i[0]);
      irq_ack_i <= 1'b1;
      external_irq_pin_i <= 1'b0;
      periph_irq_i <= 1'b0;
      @(posedge mclk_i);
      irq_ack_i <= 1'b0;
      @(posedge mclk_i);
    end
  endtask
  task t_mask;
    wreg(14'h000b, 8'h80);
    go_sleep(8'h01);
    chg;
    wait_for(20, 0);
    chk(n[7:0], 8'h14);
    rreg(14'h000b, 8'h81);
    master_clear_pin_n_i <= 1'b0;
    wait_for(8, 2);
    chk(n < 8, 8'h01);
    rreg(14'h0003, 8'h10);
    rreg(14'h000b, 8'h00);
    master_clear_pin_n_i <= 1'b1;
    wait_for(40, 1);
  endtask
  task t_pend;
    wreg(14'h000b, 8'h08);
    chg;
    @(posedge mclk_i);
    go_sleep(8'h00);
    @(posedge mclk_i);
    chk(resume_o, 8'h01);
    chk(branch_vec_o, 8'h00);
  endtask
  task t_xtal;
    config_strap_i <= 8'h08;
    rst_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    wait_for(40, 1);
    wreg(14'h000b, 8'h08);
    go_sleep(8'h01);
    chg;
    wait_for(1100, 0);
    chk(n > 1020 && n < 1035, 8'h01);
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_reset;
    t_wdclr;
    t_wdt_sleep;
    t_irq;
    t_mask;
    t_pend;
    t_xtal;
    close_out;
  end
  initial begin
    repeat (6000) @(posedge mclk_i);
    n_fail++;
    close_out;
  end
endmodule
